/* src/sram_host_ctl.sv */
// Host controller driving an asynchronous 512K x 8 static memory by its pins.
// Assumes single mclk domain; the board resolves the shared data wires.
`timescale 1ns/1ps
module sram_host_ctl (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  // User request
  input  wire logic                              req_valid,
  input  wire logic                              req_write,
  input  wire logic [sram_ctl_pkg::ADDR_W-1:0]   req_addr,
  input  wire logic [sram_ctl_pkg::DATA_W-1:0]   req_wdata,
  output logic                                   req_ready,
  // User read answer
  output logic                                   rsp_valid,
  output logic      [sram_ctl_pkg::DATA_W-1:0]   rsp_rdata,
  // Retention control
  input  wire logic                              sleep_req,
  output logic                                   sleep_ack,
  // Memory pins
  output logic      [sram_ctl_pkg::ADDR_W-1:0]   word_select_lines,
  output logic                                   chip_sel_n,
  output logic                                   out_drive_n,
  output logic                                   wr_strobe_n,
  output logic      [sram_ctl_pkg::DATA_W-1:0]   shared_data_lines_o,
  output logic                                   shared_data_lines_oe_n,
  input  wire logic [sram_ctl_pkg::DATA_W-1:0]   shared_data_lines_i
);

  localparam int CW = sram_ctl_pkg::CNT_W;

  // Read sample waits access time plus two synchroniser stages
  localparam logic [CW-1:0] RD_WAIT =
    CW'(sram_ctl_pkg::ACC_CYC + 2);
  localparam logic [CW-1:0] WREL_WAIT = CW'(sram_ctl_pkg::HZ_CYC);
  localparam logic [CW-1:0] WP_WAIT =
    CW'((sram_ctl_pkg::WP_CYC > sram_ctl_pkg::HZ_CYC +
         sram_ctl_pkg::DSU_CYC) ? sram_ctl_pkg::WP_CYC :
        sram_ctl_pkg::HZ_CYC + sram_ctl_pkg::DSU_CYC + 1);
  localparam logic [CW-1:0] GAP_WAIT = CW'(sram_ctl_pkg::GAP_CYC);
  localparam logic [CW-1:0] REC_WAIT = CW'(sram_ctl_pkg::REC_CYC);

  sram_ctl_pkg::ctl_state_t state_r, state_nxt;
  logic [CW-1:0]                   cnt_r, cnt_nxt;
  logic [sram_ctl_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [sram_ctl_pkg::DATA_W-1:0] wdat_r, wdat_nxt;
  logic [sram_ctl_pkg::DATA_W-1:0] rdat_r, rdat_nxt;
  logic                            cs_n_r, cs_n_nxt;
  logic                            oe_n_r, oe_n_nxt;
  logic                            we_n_r, we_n_nxt;
  logic                            doe_n_r, doe_n_nxt;
  logic                            rdy_r, rdy_nxt;
  logic                            rv_r, rv_nxt;
  logic                            ack_r, ack_nxt;
  logic [sram_ctl_pkg::DATA_W-1:0] din_sync;

  // Returned data passes two flops before use
  pin_sync #(
    .W (sram_ctl_pkg::DATA_W)
  ) u_din_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (shared_data_lines_i),
    .sync_out (din_sync)
  );

  // Next-state logic for the pin sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - CW'(1) : cnt_r;
    addr_nxt  = addr_r;
    wdat_nxt  = wdat_r;
    rdat_nxt  = rdat_r;
    cs_n_nxt  = cs_n_r;
    oe_n_nxt  = oe_n_r;
    we_n_nxt  = we_n_r;
    doe_n_nxt = doe_n_r;
    rdy_nxt   = 1'b0;
    rv_nxt    = 1'b0;
    ack_nxt   = ack_r;
    case (state_r)
      sram_ctl_pkg::ST_IDLE:
      begin
        rdy_nxt = ~sleep_req;
        if (sleep_req)
        begin
          cs_n_nxt  = 1'b1;
          state_nxt = sram_ctl_pkg::ST_SLEEP;
        end
        else if (req_valid && rdy_r)
        begin
          rdy_nxt  = 1'b0;
          // Address moves only with select and strobe high
          addr_nxt = req_addr;
          wdat_nxt = req_wdata;
          if (req_write)
          begin
            // Select low, output drive high, data not yet driven
            cs_n_nxt  = 1'b0;
            oe_n_nxt  = 1'b1;
            cnt_nxt   = WREL_WAIT;
            state_nxt = sram_ctl_pkg::ST_WREL;
          end
          else
          begin
            cs_n_nxt  = 1'b0;
            oe_n_nxt  = 1'b0;
            we_n_nxt  = 1'b1;
            cnt_nxt   = RD_WAIT;
            state_nxt = sram_ctl_pkg::ST_RSEL;
          end
        end
      end
      sram_ctl_pkg::ST_RSEL:
        if (cnt_r == '0)
        begin
          rdat_nxt  = din_sync;
          state_nxt = sram_ctl_pkg::ST_RDONE;
        end
      sram_ctl_pkg::ST_RDONE:
      begin
        // Release memory outputs, then wait out the least cycle time
        cs_n_nxt  = 1'b1;
        oe_n_nxt  = 1'b1;
        rv_nxt    = 1'b1;
        cnt_nxt   = GAP_WAIT;
        state_nxt = sram_ctl_pkg::ST_GAP;
      end
      sram_ctl_pkg::ST_WREL:
        // Memory outputs are already floating before host drives
        if (cnt_r == '0)
        begin
          we_n_nxt  = 1'b0;
          doe_n_nxt = 1'b0;
          cnt_nxt   = WP_WAIT;
          state_nxt = sram_ctl_pkg::ST_WSTB;
        end
      sram_ctl_pkg::ST_WSTB:
        // Strobe and select end together; data held through the edge
        if (cnt_r == '0)
        begin
          we_n_nxt  = 1'b1;
          cs_n_nxt  = 1'b1;
          cnt_nxt   = GAP_WAIT;
          state_nxt = sram_ctl_pkg::ST_GAP;
        end
      sram_ctl_pkg::ST_GAP:
      begin
        // Stop driving data one cycle after the write ends
        doe_n_nxt = 1'b1;
        if (cnt_r == '0)
        begin
          rdy_nxt   = ~sleep_req;
          state_nxt = sram_ctl_pkg::ST_IDLE;
        end
      end
      sram_ctl_pkg::ST_SLEEP:
      begin
        ack_nxt = 1'b1;
        if (!sleep_req)
        begin
          ack_nxt   = 1'b0;
          cnt_nxt   = REC_WAIT;
          state_nxt = sram_ctl_pkg::ST_WAKE;
        end
      end
      sram_ctl_pkg::ST_WAKE:
        if (cnt_r == '0)
        begin
          rdy_nxt   = 1'b1;
          state_nxt = sram_ctl_pkg::ST_IDLE;
        end
      default:
        state_nxt = sram_ctl_pkg::ST_IDLE;
    endcase
  end

  // Registers for sequencer and pins
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      state_r <= sram_ctl_pkg::ST_IDLE;
      cnt_r   <= '0;
      addr_r  <= '0;
      wdat_r  <= '0;
      rdat_r  <= '0;
      cs_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      we_n_r  <= 1'b1;
      doe_n_r <= 1'b1;
      rdy_r   <= 1'b0;
      rv_r    <= 1'b0;
      ack_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      wdat_r  <= wdat_nxt;
      rdat_r  <= rdat_nxt;
      cs_n_r  <= cs_n_nxt;
      oe_n_r  <= oe_n_nxt;
      we_n_r  <= we_n_nxt;
      doe_n_r <= doe_n_nxt;
      rdy_r   <= rdy_nxt;
      rv_r    <= rv_nxt;
      ack_r   <= ack_nxt;
    end

  // Outputs straight from flops
  assign req_ready              = rdy_r;
  assign rsp_valid              = rv_r;
  assign rsp_rdata              = rdat_r;
  assign sleep_ack              = ack_r;
  assign word_select_lines      = addr_r;
  assign chip_sel_n             = cs_n_r;
  assign out_drive_n            = oe_n_r;
  assign wr_strobe_n            = we_n_r;
  assign shared_data_lines_o    = wdat_r;
  assign shared_data_lines_oe_n = doe_n_r;

endmodule

/* common/sram_ctl_pkg.sv */
// Constants for the host-side controller of an asynchronous 512K x 8 SRAM.
// Assumes a 100 MHz system clock; all pin timing is counted in cycles.
package sram_ctl_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam longint MEM_WORDS = 524288;

  // Clock period in picoseconds
  localparam int CLK_PS = 10000;

  // Pin timing figures in picoseconds
  localparam int T_CYCLE_PS = 8000;   // Least read or write cycle time
  localparam int T_ACC_PS   = 8000;   // Worst access from select or address
  localparam int T_WP_PS    = 6500;   // Least write strobe width
  localparam int T_DSU_PS   = 5000;   // Least data setup to end of write
  localparam int T_HZ_PS    = 3000;   // Worst output release time
  localparam int T_REC_PS   = 8000;   // Wait after retention ends

  // Rounds a least time up to whole cycles, never under one
  function automatic int min_cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACC_CYC  = min_cyc(T_ACC_PS);
  localparam int WP_CYC   = min_cyc(T_WP_PS);
  localparam int DSU_CYC  = min_cyc(T_DSU_PS);
  localparam int HZ_CYC   = min_cyc(T_HZ_PS);
  localparam int GAP_CYC  = min_cyc(T_CYCLE_PS);
  localparam int REC_CYC  = min_cyc(T_REC_PS);

  localparam int CNT_W = 4;

  // Controller states, Gray coded along read and write paths except the ST_GAP return to ST_IDLE
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RSEL  = 3'b001,
    ST_RDONE = 3'b011,
    ST_WREL  = 3'b010,
    ST_WSTB  = 3'b110,
    ST_GAP   = 3'b111,
    ST_SLEEP = 3'b101,
    ST_WAKE  = 3'b100
  } ctl_state_t;

endpackage

/* src/pin_sync.sv */
// Two-stage synchroniser for the shared data lines coming back from memory.
// Assumes the pins are asynchronous to mclk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  // First stage feeds only the second
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
    end
    else
    begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end

  assign sync_out = stage2_r;

endmodule

/* test/sram_host_ctl_chk.sv */
// Pin sequencing checker for the host memory controller.
// Bound onto sram_host_ctl; sees its ports only.
`timescale 1ns/1ps
module sram_host_ctl_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Memory pins
  input wire logic [18:0] word_select_lines,
  input wire logic        chip_sel_n,
  input wire logic        out_drive_n,
  input wire logic        wr_strobe_n,
  input wire logic [7:0]  shared_data_lines_o,
  input wire logic        shared_data_lines_oe_n,
  // User side
  input wire logic        rsp_valid,
  input wire logic        sleep_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Read, write and retention sequencing on the pins
  a_read_no_strobe: assert property (
    !chip_sel_n && !out_drive_n |-> wr_strobe_n)
    else $error("strobe low during read");
  a_read_answer: assert property (
    $fell(out_drive_n) |-> ##5 rsp_valid)
    else $error("read answer late");
  a_addr_held: assert property (
    !chip_sel_n && !$past(chip_sel_n) |-> $stable(word_select_lines))
    else $error("address moved while selected");
  a_addr_move_idle: assert property (
    !$stable(word_select_lines) |-> $past(chip_sel_n) && $past(wr_strobe_n))
    else $error("address moved in a cycle");
  a_strobe_width: assert property (
    $fell(wr_strobe_n) |-> (!wr_strobe_n && !chip_sel_n)[*3])
    else $error("write pulse too short");
  a_data_setup: assert property (
    !wr_strobe_n |-> !shared_data_lines_oe_n && $stable(shared_data_lines_o))
    else $error("write data not held");
  a_data_hold: assert property (
    $rose(wr_strobe_n) |-> !shared_data_lines_oe_n)
    else $error("write data dropped early");
  a_no_contention: assert property (
    !out_drive_n |-> shared_data_lines_oe_n)
    else $error("host drives during read");
  a_cycle_gap: assert property (
    $rose(chip_sel_n) |-> chip_sel_n ##1 chip_sel_n)
    else $error("cycles too close");
  a_sleep_wake: assert property (
    sleep_ack || $fell(sleep_ack) |-> chip_sel_n ##1 chip_sel_n)
    else $error("access during retention");
endmodule

/* test/sram_mem_model.sv */
// Behavioural model of the 512K x 8 static memory at its pins.
// Driven by the controller; the bench resolves the data wires.
`timescale 1ns/1ps
module sram_mem_model (
  // Memory pins
  input  wire logic [18:0] word_select_lines,
  input  wire logic        chip_sel_n,
  input  wire logic        out_drive_n,
  input  wire logic        wr_strobe_n,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out
);
  logic [7:0] mem [0:524287];
  logic       wr_on;
  logic       drv;
  // Write window is the overlap of select and strobe
  assign wr_on = !chip_sel_n && !wr_strobe_n;
  // Drive only in read mode, release at once otherwise
  assign drv = !chip_sel_n && !out_drive_n && wr_strobe_n;
  // Store on whichever control rises first
  always @(negedge wr_on)
    mem[word_select_lines] = dq_in;
  // Data follows the address; floating lines show inverted data
  assign dq_out = drv ? mem[word_select_lines]
                      : ~mem[word_select_lines];
endmodule

/* test/sram_host_ctl_bench.sv */
// Self-checking bench for the host controller and a memory model.
// Single 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module sram_host_ctl_bench;
  logic        mclk = 0;
  logic        sys_rst = 1;
  logic        req_valid = 0;
  logic        req_write = 0;
  logic [18:0] req_addr = '0;
  logic [7:0]  req_wdata = '0;
  logic        sleep_req = 0;
  logic        req_ready, rsp_valid, sleep_ack;
  logic        cs_n, od_n, ws_n, oe_n;
  logic [18:0] wsl;
  logic [7:0]  rsp_rdata, dq_o, dq_m, dq;
  int          fails = 0;
  int          checked = 0;
  // Clock and shared data wire
  always #5 mclk = ~mclk;
  assign dq = !oe_n ? dq_o : dq_m;
  sram_host_ctl dut (.mclk(mclk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .sleep_req(sleep_req), .sleep_ack(sleep_ack),
    .word_select_lines(wsl), .chip_sel_n(cs_n), .out_drive_n(od_n),
    .wr_strobe_n(ws_n), .shared_data_lines_o(dq_o),
    .shared_data_lines_oe_n(oe_n), .shared_data_lines_i(dq));
  sram_mem_model mem (.word_select_lines(wsl), .chip_sel_n(cs_n),
    .out_drive_n(od_n), .wr_strobe_n(ws_n), .dq_in(dq), .dq_out(dq_m));
  // Compare helpers
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask
  task automatic finish_test;
    $display("Checks %0d, errors %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One request, held until taken; entered at a falling edge
  task automatic xfer(input logic w, input logic [18:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    if (req_ready !== 1'b1)
      fails++;
    @(negedge mclk);
    req_valid = 0;
    // Let an edge pass with no request before the next call
    @(negedge mclk);
  endtask
  // Read one byte and compare the answer
  task automatic rd(input logic [18:0] a, input logic [7:0] e);
    int n;
    n = 0;
    xfer(1'b0, a, 8'h00);
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    chk_bit(rsp_valid, 1'b1);
    chk_byte(rsp_rdata, e);
  endtask
  // Pins idle after reset
  task automatic t_reset;
    chk_bit(cs_n, 1'b1);
    chk_bit(ws_n, 1'b1);
    chk_bit(oe_n, 1'b1);
    chk_bit(od_n, 1'b1);
  endtask
  // Walking address lines, end addresses and an overwrite
  task automatic t_walk;
    for (int i = 0; i < 19; i++)
      xfer(1'b1, 19'h00001 << i, 8'(i * 17));
    xfer(1'b1, 19'h00000, 8'h5A);
    xfer(1'b1, 19'h7FFFF, 8'hC3);
    for (int i = 0; i < 19; i++)
      rd(19'h00001 << i, 8'(i * 17));
    rd(19'h00000, 8'h5A);
    xfer(1'b1, 19'h00000, 8'hA5);
    rd(19'h00000, 8'hA5);
  endtask
  // Retention entry, ready low while asleep, access after wake
  task automatic t_sleep;
    int n;
    n = 0;
    sleep_req = 1;
    while (sleep_ack !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    chk_bit(sleep_ack, 1'b1);
    chk_bit(cs_n, 1'b1);
    chk_bit(req_ready, 1'b0);
    @(negedge mclk);
    sleep_req = 0;
    rd(19'h7FFFF, 8'hC3);
    chk_bit(sleep_ack, 1'b0);
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(negedge mclk);
    sys_rst = 0;
    t_reset();
    t_walk();
    t_sleep();
    finish_test();
  end
  // Watchdog
  initial
  begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
bind sram_host_ctl sram_host_ctl_chk chk (.mclk(mclk), .sys_rst(sys_rst),
  .word_select_lines(word_select_lines), .chip_sel_n(chip_sel_n),
  .out_drive_n(out_drive_n), .wr_strobe_n(wr_strobe_n),
  .shared_data_lines_o(shared_data_lines_o),
  .shared_data_lines_oe_n(shared_data_lines_oe_n),
  .rsp_valid(rsp_valid), .sleep_ack(sleep_ack));
